//--- inc/cfl_pkg.sv
package cfl_pkg;
  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 50;
  // Least low time of the status line after a clear, rounded up
  localparam int STATUS_LOW_MIN_NS = 45000;
  localparam int STATUS_LOW_CYC = (STATUS_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STATUS_CNT_W = 10;
  // Link clock falling edges needed after done reads high
  localparam logic [1:0] INIT_FALL_EDGES = 2'h2;

  // ************************************************************
  // Stream shape
  // ************************************************************
  localparam int BYTE_W = 8;
  localparam int STREAM_BYTES_DEF = 16;
  localparam int BYTE_CNT_W = 16;
  localparam int SYNC_W = BYTE_W + 5;

  // ************************************************************
  // Loader states
  // ************************************************************
  typedef enum logic [2:0] {
    CFL_CLEAR,
    CFL_WAIT_STATUS,
    CFL_LOAD,
    CFL_DONE_WAIT,
    CFL_INIT,
    CFL_USER,
    CFL_ERROR,
    CFL_HALT
  } cfl_state_t;
endpackage

//--- inc/cfl_pin_if.sv
// Synchronised pin view shared between the pin stage and the loader
interface cfl_pin_if;
  logic link_rise;
  logic link_fall;
  logic [cfl_pkg::BYTE_W-1:0] data;
  logic reconfig_n;
  logic status_high;
  logic done_high;
  logic byte_mode;
  modport src (output link_rise, link_fall, data, reconfig_n, status_high, done_high, byte_mode);
  modport dst (input link_rise, link_fall, data, reconfig_n, status_high, done_high, byte_mode);
endinterface

//--- logic/cfl_pin_sync.sv
module cfl_pin_sync (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic link_clk_i,
  input wire logic [cfl_pkg::BYTE_W-1:0] data_i,
  input wire logic reconfig_n_i,
  input wire logic status_n_i,
  input wire logic cfg_done_i,
  input wire logic byte_load_mode_i,
  cfl_pin_if.src pins
);
  import cfl_pkg::*;

  logic [SYNC_W-1:0] meta_r, meta_nxt;
  logic [SYNC_W-1:0] sync_r, sync_nxt;
  logic link_old_r, link_old_nxt;

  // Data rides the same two stages as the link clock so a sampled
  // edge always sees the byte that stood at that edge
  always_comb begin
    meta_nxt = {link_clk_i, reconfig_n_i, status_n_i, cfg_done_i, byte_load_mode_i, data_i};
    sync_nxt = meta_r;
    link_old_nxt = sync_r[SYNC_W-1];
  end

  // Reset reads as reconfigure held, so the loader starts in clear
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_r <= '0;
      sync_r <= '0;
      link_old_r <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      link_old_r <= link_old_nxt;
    end
  end

  // Edge detection looks only at the second stage and later
  assign pins.link_rise = sync_r[SYNC_W-1] & ~link_old_r;
  assign pins.link_fall = ~sync_r[SYNC_W-1] & link_old_r;
  assign pins.reconfig_n = sync_r[SYNC_W-2];
  assign pins.status_high = sync_r[SYNC_W-3];
  assign pins.done_high = sync_r[SYNC_W-4];
  assign pins.byte_mode = sync_r[SYNC_W-5];
  assign pins.data = sync_r[BYTE_W-1:0];
endmodule // cfl_pin_sync

//--- logic/cfl_loader.sv
// Behaviour
// - Bits keep being accepted until the stream byte count is reached or the done line reads high.
// - Done line is open drain; initialization waits until it reads high.
// - Initialization needs no user startup clock at all.
// - Chained devices share lines; shared done makes user entry simultaneous.
// - On an error while loading, before done is released, status is pulled low; a low status stops loading.
// - Byte mode accepts a whole byte on every link clock.
// - Data is captured on the rising link clock edge.
// - Reconfigure low abandons user mode and restarts configuration.
// - Done line held low from power up until the whole stream is in; in byte mode until all but the last byte.
module cfl_loader #(
  parameter int STREAM_BYTES = cfl_pkg::STREAM_BYTES_DEF
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic link_clk_i,
  input wire logic [cfl_pkg::BYTE_W-1:0] data_i,
  input wire logic reconfig_n_i,
  input wire logic status_n_i,
  output logic status_n_o,
  output logic status_n_oe_o,
  input wire logic cfg_done_i,
  output logic cfg_done_o,
  output logic cfg_done_oe_o,
  input wire logic byte_load_mode_i,
  input wire logic cfg_error_i,
  output logic [cfl_pkg::BYTE_W-1:0] cfg_byte_o,
  output logic cfg_byte_valid_o,
  output logic loading_o,
  output logic user_mode_o
);
  import cfl_pkg::*;

  localparam logic [BYTE_CNT_W-1:0] LAST_SERIAL = BYTE_CNT_W'(STREAM_BYTES);
  localparam logic [BYTE_CNT_W-1:0] LAST_BYTE = BYTE_CNT_W'(STREAM_BYTES - 1);
  localparam logic [STATUS_CNT_W-1:0] STATUS_LAST = STATUS_CNT_W'(STATUS_LOW_CYC - 1);

  cfl_pin_if pins ();

  // ************************************************************
  // Pin synchronisation
  // ************************************************************
  cfl_pin_sync u_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .link_clk_i(link_clk_i),
    .data_i(data_i),
    .reconfig_n_i(reconfig_n_i),
    .status_n_i(status_n_i),
    .cfg_done_i(cfg_done_i),
    .byte_load_mode_i(byte_load_mode_i),
    .pins(pins)
  );

  // ************************************************************
  // Loader state
  // ************************************************************
  cfl_state_t state_r, state_nxt;
  logic [STATUS_CNT_W-1:0] hold_r, hold_nxt;
  logic [BYTE_W-1:0] shift_r, shift_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [BYTE_CNT_W-1:0] bytes_r, bytes_nxt;
  logic [1:0] falls_r, falls_nxt;
  logic [BYTE_W-1:0] byte_r, byte_nxt;
  logic valid_r, valid_nxt;
  logic accept;
  logic [BYTE_CNT_W-1:0] done_at;

  // Byte mode raises done one byte early, the last byte lands only while done still reads low
  assign done_at = pins.byte_mode ? LAST_BYTE : LAST_SERIAL;
  // Capture only while status reads high and stream is not yet full
  assign accept = pins.link_rise && pins.status_high && (bytes_r < LAST_SERIAL);

  // Next state, capture and counters
  always_comb begin
    state_nxt = state_r;
    hold_nxt = hold_r;
    shift_nxt = shift_r;
    bit_nxt = bit_r;
    bytes_nxt = bytes_r;
    falls_nxt = falls_r;
    byte_nxt = byte_r;
    valid_nxt = 1'b0;
    if ((state_r == CFL_LOAD || state_r == CFL_DONE_WAIT) && accept) begin
      if (pins.byte_mode) begin
        byte_nxt = pins.data;
        valid_nxt = 1'b1;
        bytes_nxt = bytes_r + 1'b1;
      end else begin
        shift_nxt = {shift_r[BYTE_W-2:0], pins.data[0]};
        bit_nxt = bit_r + 1'b1;
        if (bit_r == 3'h7) begin
          byte_nxt = {shift_r[BYTE_W-2:0], pins.data[0]};
          valid_nxt = 1'b1;
          bytes_nxt = bytes_r + 1'b1;
        end
      end
    end
    case (state_r)
      CFL_CLEAR: begin
        // Hold status low for its least width and while reconfigure is low
        if (hold_r != STATUS_LAST) begin
          hold_nxt = hold_r + 1'b1;
        end else if (pins.reconfig_n) begin
          state_nxt = CFL_WAIT_STATUS;
        end
      end
      CFL_WAIT_STATUS: begin
        // Another chain member may still hold status low
        if (pins.status_high) begin
          state_nxt = CFL_LOAD;
        end
      end
      CFL_LOAD: begin
        if (cfg_error_i) begin
          state_nxt = CFL_ERROR;
        end else if (!pins.status_high) begin
          state_nxt = CFL_HALT;
        end else if (bytes_nxt >= done_at) begin
          state_nxt = CFL_DONE_WAIT;
        end
      end
      CFL_DONE_WAIT: begin
        // Released but a chain member may still pull done low
        if (!pins.status_high) begin
          state_nxt = CFL_HALT;
        end else if (pins.done_high) begin
          state_nxt = CFL_INIT;
          falls_nxt = 2'h0;
        end
      end
      CFL_INIT: begin
        // Counted on the link clock only, no user startup clock used
        if (pins.link_fall) begin
          falls_nxt = falls_r + 1'b1;
          if (falls_r + 1'b1 == INIT_FALL_EDGES) begin
            state_nxt = CFL_USER;
          end
        end
      end
      CFL_USER, CFL_ERROR, CFL_HALT: begin
        // Only reconfigure leaves these; no automatic restart
        state_nxt = state_r;
      end
      default: begin
        state_nxt = CFL_CLEAR;
      end
    endcase
    // Reconfigure low overrides state, counters and the valid pulse
    if (!pins.reconfig_n) begin
      state_nxt = CFL_CLEAR;
      hold_nxt = '0;
      bit_nxt = 3'h0;
      bytes_nxt = '0;
      falls_nxt = 2'h0;
      valid_nxt = 1'b0;
    end
  end

  // Register stage
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= CFL_CLEAR;
      hold_r <= '0;
      shift_r <= '0;
      bit_r <= 3'h0;
      bytes_r <= '0;
      falls_r <= 2'h0;
      byte_r <= '0;
      valid_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      hold_r <= hold_nxt;
      shift_r <= shift_nxt;
      bit_r <= bit_nxt;
      bytes_r <= bytes_nxt;
      falls_r <= falls_nxt;
      byte_r <= byte_nxt;
      valid_r <= valid_nxt;
    end
  end

  // ************************************************************
  // Pin drive
  // ************************************************************
  // Open-drain lines only ever drive low; pull-ups make the high
  assign status_n_o = 1'b0;
  assign status_n_oe_o = (state_r == CFL_CLEAR) || (state_r == CFL_ERROR);
  assign cfg_done_o = 1'b0;
  assign cfg_done_oe_o = (state_r == CFL_CLEAR) || (state_r == CFL_WAIT_STATUS) ||
                         (state_r == CFL_LOAD) || (state_r == CFL_ERROR) || (state_r == CFL_HALT);
  assign cfg_byte_o = byte_r;
  assign cfg_byte_valid_o = valid_r;
  assign loading_o = (state_r == CFL_LOAD) || (state_r == CFL_DONE_WAIT);
  assign user_mode_o = (state_r == CFL_USER);

  // ************************************************************
  // Checks
  // ************************************************************
  sequence s_reconf_drop;
    !pins.reconfig_n;
  endsequence
  sequence s_status_held;
    status_n_oe_o [*8];
  endsequence

  property p_reconf_clear;
    @(posedge clk_i) disable iff (!nrst_i) s_reconf_drop |=> s_status_held;
  endproperty
  a_reconf_clear: assert property (p_reconf_clear) else $error("status not held after reconfigure");

  property p_done_low;
    @(posedge clk_i) disable iff (!nrst_i) (state_r == CFL_LOAD) |-> (cfg_done_oe_o && !cfg_done_o);
  endproperty
  a_done_low: assert property (p_done_low) else $error("done released during load");

  property p_init_after_done;
    @(posedge clk_i) disable iff (!nrst_i) (state_r == CFL_INIT && $past(state_r) != CFL_INIT) |->
      $past(pins.done_high);
  endproperty
  a_init_after_done: assert property (p_init_after_done) else $error("init before done high");

  property p_user_two_falls;
    @(posedge clk_i) disable iff (!nrst_i) $rose(user_mode_o) |-> $past(pins.link_fall) && $past(falls_r) == 2'h1;
  endproperty
  a_user_two_falls: assert property (p_user_two_falls) else $error("user mode without two falls");

  property p_error_pull;
    @(posedge clk_i) disable iff (!nrst_i) (state_r == CFL_LOAD && cfg_error_i && pins.reconfig_n) |=>
      status_n_oe_o && !loading_o;
  endproperty
  a_error_pull: assert property (p_error_pull) else $error("error did not pull status");

  property p_chain_halt;
    @(posedge clk_i) disable iff (!nrst_i) (state_r == CFL_LOAD && !pins.status_high && pins.reconfig_n) |=>
      state_r == CFL_HALT || state_r == CFL_ERROR ##1 !cfg_byte_valid_o;
  endproperty
  a_chain_halt: assert property (p_chain_halt) else $error("load continued under low status");

  property p_byte_each_rise;
    @(posedge clk_i) disable iff (!nrst_i) (loading_o && accept && pins.byte_mode && pins.reconfig_n) |=>
      cfg_byte_valid_o && cfg_byte_o == $past(pins.data);
  endproperty
  a_byte_each_rise: assert property (p_byte_each_rise) else $error("byte not taken on rise");

  property p_valid_on_rise;
    @(posedge clk_i) disable iff (!nrst_i) cfg_byte_valid_o |-> $past(pins.link_rise) && $past(pins.status_high);
  endproperty
  a_valid_on_rise: assert property (p_valid_on_rise) else $error("byte without rising edge");

  property p_serial_bit;
    @(posedge clk_i) disable iff (!nrst_i) (loading_o && accept && !pins.byte_mode && pins.reconfig_n) |=>
      shift_r[0] == $past(pins.data[0]);
  endproperty
  a_serial_bit: assert property (p_serial_bit) else $error("serial bit not shifted");
endmodule // cfl_loader

//--- sim/cfl_host_model.sv
// ************************************************************
// Host side of the configuration link
// ************************************************************
module cfl_host_model (
  input wire logic clk_i,
  output logic link_clk_o,
  output logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // Link clock stands low between frames
  initial begin
    link_clk_o = 1'b0;
    data_o = 8'h00;
  end

  // Half a link period is four system clocks, so data stays put well around each rise
  task automatic half();
    repeat (4) @(posedge clk_i);
    #1;
  endtask

  // One link clock pulse
  task automatic pulse();
    half();
    link_clk_o = 1'b1;
    half();
    link_clk_o = 1'b0;
  endtask

  // Serial puts MSB first on bit zero, byte mode one byte per pulse
  task automatic send(input logic [7:0] b, input logic bm);
    for (int i = 0; i < (bm ? 1 : 8); i++) begin
      data_o = bm ? b : {~data_o[7:1], b[7 - i]};
      pulse();
    end
    // Stale data is inverted so it can never pass for a fresh value
    data_o = ~data_o;
    // One idle clock so the next frame never drives data in this same step
    @(posedge clk_i);
    #1;
  endtask

  // Extra falling edges that let initialization finish into user mode
  task automatic falls(input int n);
    repeat (n) pulse();
  endtask
endmodule // cfl_host_model

//--- sim/serial_config_loader_tb.sv
module serial_config_loader_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // ************************************************************
  // Signals
  // ************************************************************
  localparam int NB = 4;
  logic clk_i, nrst_i, reconfig_n_i, byte_load_mode_i, cfg_error_i, pull_status, other_hold;
  logic link_clk, status_n_o, status_n_oe_o, cfg_done_o, cfg_done_oe_o, cfg_byte_valid_o, loading_o, user_mode_o;
  logic [7:0] data, cfg_byte_o;
  wire logic status_w;
  wire logic done_w;
  int bad_count = 0;
  int total_checks = 0;
  logic [7:0] got[$];
  logic [7:0] sent[$];

  // Open drain lines with pull-ups; other_hold plays a slower chained device
  assign status_w = ~((status_n_oe_o & ~status_n_o) | pull_status);
  assign done_w = ~((cfg_done_oe_o & ~cfg_done_o) | other_hold);

  cfl_loader #(.STREAM_BYTES(NB)) cfl_loader_i (.clk_i, .nrst_i, .link_clk_i(link_clk), .data_i(data),
    .reconfig_n_i, .status_n_i(status_w), .status_n_o, .status_n_oe_o, .cfg_done_i(done_w), .cfg_done_o,
    .cfg_done_oe_o, .byte_load_mode_i, .cfg_error_i, .cfg_byte_o, .cfg_byte_valid_o, .loading_o, .user_mode_o);

  cfl_host_model cfl_host_model_i (.clk_i, .link_clk_o(link_clk), .data_o(data));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Collect each assembled byte mid-cycle, where the registered pulse has settled
  always @(negedge clk_i) begin
    if (cfg_byte_valid_o === 1'b1) got.push_back(cfg_byte_o);
  end

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Bytes taken before an error or a halt cuts the stream
  function automatic int exp_count(input int err_at, input int halt_at);
    if (err_at >= 0) return err_at;
    if (halt_at >= 0) return halt_at;
    return NB;
  endfunction

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ************************************************************
  // One configuration cycle
  // ************************************************************
  task automatic run(input logic bm, input int err_at, input int halt_at);
    logic [7:0] b;
    int n;
    n = exp_count(err_at, halt_at);
    reconfig_n_i = 1'b0;
    byte_load_mode_i = bm;
    other_hold = 1'b1;
    repeat (5) tick();
    chk(user_mode_o, 0);
    chk(cfg_done_oe_o, 1);
    chk(cfg_done_o, 0);
    chk(status_n_o, 0);
    chk(loading_o, 0);
    reconfig_n_i = 1'b1;
    if (halt_at >= 0) begin
      // A slower chain member keeps status low; clocks sent meanwhile are ignored
      pull_status = 1'b1;
      repeat (1000) tick();
      got.delete();
      cfl_host_model_i.send(8'($urandom), bm);
      chk(loading_o, 0);
      chk(got.size(), 0);
      pull_status = 1'b0;
    end
    for (int i = 0; i < 3000; i++) begin
      if (status_w === 1'b1) break;
      tick();
    end
    chk(status_w, 1);
    repeat (3) tick();
    chk(loading_o, 1);
    got.delete();
    sent.delete();
    for (int k = 0; k < NB; k++) begin
      chk(cfg_done_oe_o, (bm && k == NB - 1 && n == NB) ? 0 : 1);
      if (k == err_at) begin
        cfg_error_i = 1'b1;
        tick();
        cfg_error_i = 1'b0;
      end
      if (k == halt_at) pull_status = 1'b1;
      b = 8'($urandom);
      sent.push_back(b);
      cfl_host_model_i.send(b, bm);
    end
    repeat (4) tick();
    chk(got.size(), n);
    for (int k = 0; k < n; k++) chk(got[k], sent[k]);
    if (n == NB) begin
      chk(cfg_done_oe_o, 0);
      cfl_host_model_i.falls(2);
      repeat (8) tick();
      chk(user_mode_o, 0);
      other_hold = 1'b0;
      repeat (6) tick();
      chk(user_mode_o, 0);
      cfl_host_model_i.falls(2);
      repeat (6) tick();
      chk(user_mode_o, 1);
    end else begin
      // No restart may happen by itself after a fault
      repeat (100) tick();
      chk(status_n_oe_o, err_at >= 0);
      chk(cfg_done_oe_o, 1);
      chk(user_mode_o, 0);
    end
    pull_status = 1'b0;
    $display("test end bm=%0d err=%0d halt=%0d", bm, err_at, halt_at);
  endtask

  // ************************************************************
  // Main sequence and watchdog
  // ************************************************************
  initial begin
    nrst_i = 1'b0;
    reconfig_n_i = 1'b1;
    byte_load_mode_i = 1'b0;
    cfg_error_i = 1'b0;
    pull_status = 1'b0;
    other_hold = 1'b0;
    void'($urandom(94));
    repeat (12) @(posedge clk_i);
    #1;
    nrst_i = 1'b1;
    run(1'b0, -1, -1);
    run(1'b1, -1, -1);
    run(1'b0, 2, -1);
    run(1'b1, -1, 1);
    wrap_up();
  end

  // Four cycles need well under a third of this span
  initial begin
    #1_000_000;
    bad_count++;
    wrap_up();
  end
endmodule // serial_config_loader_tb
